// ### src/lpb_pkg.sv
/*
  constants, encodings and decode helpers for the low-power ddr2 burst
  read / write / terminate block.
  assumes: command and data are presented at link-clock granularity,
  one rising-edge and one falling-edge sample per link clock.
*/
package lpb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus and field geometry
  localparam int CA_W     = 10;
  localparam int BANK_W   = 3;
  localparam int COL_W    = 11;
  localparam int ADDR_W   = BANK_W + COL_W;
  localparam int CA_EN    = 0;   // rising-edge bit high for rw and terminate
  localparam int CA_CLASS = 1;   // low for rw, high for terminate
  localparam int CA_DIR   = 2;   // high read, low write
  localparam int CA_SUB   = 3;   // low selects terminate
  localparam int COL_R_LO = 5;
  localparam int COL_R_HI = 6;
  localparam int COL_F_LO = 1;
  localparam int COL_F_HI = 9;
  localparam int BANK_LO  = 7;
  localparam int BANK_HI  = 9;
  localparam int WRAP_W   = 3;   // low pair-index bits that wrap inside a burst

  ////////////////////////////////////////////////////////////////////////////
  // burst length codes and values after reset
  localparam logic [1:0] BL_CODE_4  = 2'h0;
  localparam logic [1:0] BL_CODE_8  = 2'h1;
  localparam logic [1:0] BL_CODE_16 = 2'h2;
  localparam logic [1:0] BL_RST     = BL_CODE_4;
  localparam logic [3:0] RL_RST     = 4'h3;
  localparam logic [3:0] WL_RST     = 4'h1;

  // pipe tap offsets: read tap one short (output register), write one long
  localparam logic [3:0] RD_TAP_TRIM = 4'h1;
  localparam logic [3:0] WR_TAP_EXT  = 4'h1;
  localparam logic [3:0] TAP_MIN     = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // link clocks per burst for a length code
  function automatic logic [3:0] lpb_half(input logic [1:0] code);
    case (code)
      BL_CODE_8:  lpb_half = 4'h4;
      BL_CODE_16: lpb_half = 4'h8;
      default:    lpb_half = 4'h2;
    endcase
  endfunction

  // read or write command on this edge
  function automatic logic lpb_is_rw(input logic cs_n, input logic [CA_W-1:0] ca);
    lpb_is_rw = !cs_n && ca[CA_EN] && !ca[CA_CLASS];
  endfunction

  // burst terminate on this edge
  function automatic logic lpb_is_bst(input logic cs_n, input logic [CA_W-1:0] ca);
    lpb_is_bst = !cs_n && ca[CA_EN] && ca[CA_CLASS] && !ca[CA_DIR] && !ca[CA_SUB];
  endfunction

  // next pair address, wrapping inside the burst
  function automatic logic [ADDR_W-1:0] lpb_step(input logic [ADDR_W-1:0] a,
                                                 input logic [3:0]        half);
    logic [WRAP_W-1:0] m;
    logic [WRAP_W-1:0] inc;
    m   = WRAP_W'(half - 4'h1);
    inc = a[WRAP_W-1:0] + 3'h1;
    lpb_step = {a[ADDR_W-1:WRAP_W], (a[WRAP_W-1:0] & ~m) | (inc & m)};
  endfunction

endpackage

// ### src/lpb_pipe_if.sv
/*
  carrier between the burst engine and a latency pipe.
  assumes: both ends run on the link clock.
*/
`timescale 1ns/1ps
interface lpb_pipe_if #(
  parameter int AW = 8
);
  logic          in_valid;
  logic [AW-1:0] in_addr;
  logic [3:0]    delay;
  logic          out_valid;
  logic [AW-1:0] out_addr;
  logic          busy;

  modport src  (output in_valid, in_addr, delay, input  out_valid, out_addr, busy);
  modport pipe (input  in_valid, in_addr, delay, output out_valid, out_addr, busy);
endinterface

// ### src/lpb_sync.sv
/*
  two flip-flop synchroniser for quasi-static levels and toggles.
  assumes: the source holds each value for several destination clocks.
*/
`timescale 1ns/1ps
module lpb_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lpb_sync_st_t;

  lpb_sync_st_t st;
  lpb_sync_st_t next_st;

  // first stage feeds only the second
  always_comb begin
    next_st    = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= {RST_VAL, RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule

// ### src/lpb_lat_pipe.sv
/*
  variable latency pipe of pair addresses.
  assumes: delay is static while entries are in flight; delay 0 acts as 1.
*/
`timescale 1ns/1ps
module lpb_lat_pipe
  import lpb_pkg::*;
#(
  parameter int AW   = 8,
  parameter int MAXD = 16
) (
  input  wire logic ck_link,
  input  wire logic link_rst,
  lpb_pipe_if.pipe  p
);
  typedef struct packed {
    logic [MAXD-1:0]         v;
    logic [MAXD-1:0][AW-1:0] a;
  } lpb_pipe_st_t;

  lpb_pipe_st_t st;
  lpb_pipe_st_t next_st;
  logic [3:0]   tap;

  // shift one stage per link clock
  always_comb begin
    next_st   = st;
    next_st.v = {st.v[MAXD-2:0], p.in_valid};
    next_st.a = {st.a[MAXD-2:0], p.in_addr};
  end

  always_ff @(posedge ck_link) begin
    if (link_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // tap after delay registered stages
  assign tap         = (p.delay < TAP_MIN) ? 4'h0 : p.delay - TAP_MIN;
  assign p.out_valid = st.v[tap];
  assign p.out_addr  = st.a[tap];
  assign p.busy      = |st.v;
endmodule

// ### src/lpb_burst.sv
/*
  burst read, burst write and burst terminate engine of a low-power ddr2
  die: command decode, read and write latency, read preamble, seamless,
  interrupted and truncated bursts, with a small storage array.
  assumes: command, address and data pins are sampled on ck_link by the pad
  ring, one rising and one falling sample per clock; latency and burst
  length come from mode-register logic on clk_sys and change only while idle.
*/
`timescale 1ns/1ps
module lpb_burst
  import lpb_pkg::*;
#(
  parameter int DW = 8,
  parameter int AW = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic [3:0]        cfg_rl,
  input  wire logic [3:0]        cfg_wl,
  input  wire logic [1:0]        cfg_bl,
  output logic                   evt_rd_end,
  output logic                   evt_wr_end,
  output logic                   link_busy,
  input  wire logic              ck_link,
  input  wire logic              cs_n,
  input  wire logic [CA_W-1:0]   ca_r,
  input  wire logic [CA_W-1:0]   ca_f,
  input  wire logic [2*DW-1:0]   dq_i,
  output logic      [2*DW-1:0]   dq_o,
  output logic                   dq_oe,
  input  wire logic              dqs_i,
  output logic                   dqs_o,
  output logic                   dqs_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // link domain state
  typedef struct packed {
    logic [3:0]        remain;   // slots still to issue
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic              s1_v;
    logic [AW-1:0]     s1_a;
    logic              dq_oe;
    logic              dqs_oe;
    logic              dqs_o;
    logic [2*DW-1:0]   dq;
    logic              wr_v_d;
    logic              rd_tg;
    logic              wr_tg;
    logic              busy;
  } lpb_link_st_t;

  typedef struct packed {
    logic rd_tg;
    logic wr_tg;
    logic evt_rd;
    logic evt_wr;
    logic busy;
  } lpb_sys_st_t;

  lpb_link_st_t      st;
  lpb_link_st_t      next_st;
  lpb_sys_st_t       sst;
  lpb_sys_st_t       next_sst;
  logic [2*DW-1:0]   mem [0:(1<<AW)-1];
  logic              link_rst;
  logic [9:0]        cfg_l;
  logic [3:0]        rl;
  logic [3:0]        wl;
  logic [3:0]        half;
  logic [2:0]        evt_s;
  logic              rw_cmd;
  logic              bst_cmd;
  logic              inject_v;
  logic              inject_rd;
  logic [ADDR_W-1:0] cmd_addr;
  logic [ADDR_W-1:0] inject_a;

  lpb_pipe_if #(.AW(AW)) rd_p ();
  lpb_pipe_if #(.AW(AW)) wr_p ();

  ////////////////////////////////////////////////////////////////////////////
  // crossings between clk_sys and ck_link
  lpb_sync #(.W(1), .RST_VAL(1'b1)) u_rst_sync (
    .clk (ck_link),
    .rst (1'b0),
    .d   (sys_rst),
    .q   (link_rst)
  );

  lpb_sync #(.W(10), .RST_VAL({BL_RST, WL_RST, RL_RST})) u_cfg_sync (
    .clk (ck_link),
    .rst (link_rst),
    .d   ({cfg_bl, cfg_wl, cfg_rl}),
    .q   (cfg_l)
  );

  lpb_sync #(.W(3)) u_evt_sync (
    .clk (clk_sys),
    .rst (sys_rst),
    .d   ({st.busy, st.wr_tg, st.rd_tg}),
    .q   (evt_s)
  );

  assign rl   = cfg_l[3:0];
  assign wl   = cfg_l[7:4];
  assign half = lpb_half(cfg_l[9:8]);

  ////////////////////////////////////////////////////////////////////////////
  // command decode and slot generation
  assign rw_cmd   = lpb_is_rw(cs_n, ca_r);
  assign bst_cmd  = lpb_is_bst(cs_n, ca_r);
  assign cmd_addr = {ca_r[BANK_HI:BANK_LO], ca_f[COL_F_HI:COL_F_LO],
                     ca_r[COL_R_HI:COL_R_LO]};

  // a new command replaces the burst in flight; terminate issues no slot
  always_comb begin
    inject_v  = 1'b0;
    inject_rd = st.rd;
    inject_a  = st.addr;
    if (rw_cmd) begin
      inject_v  = 1'b1;
      inject_rd = ca_r[CA_DIR];
      inject_a  = cmd_addr;
    end else if (!bst_cmd && st.remain != 4'h0) begin
      inject_v  = 1'b1;
    end
  end

  // route slots into the read or write latency pipe
  assign rd_p.in_valid = inject_v && inject_rd;
  assign rd_p.in_addr  = inject_a[AW-1:0];
  assign rd_p.delay    = rl - RD_TAP_TRIM;
  assign wr_p.in_valid = inject_v && !inject_rd;
  assign wr_p.in_addr  = inject_a[AW-1:0];
  assign wr_p.delay    = wl + WR_TAP_EXT;

  lpb_lat_pipe #(.AW(AW)) u_rd_pipe (
    .ck_link  (ck_link),
    .link_rst (link_rst),
    .p        (rd_p)
  );

  lpb_lat_pipe #(.AW(AW)) u_wr_pipe (
    .ck_link  (ck_link),
    .link_rst (link_rst),
    .p        (wr_p)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next link state
  always_comb begin
    next_st = st;
    if (rw_cmd) begin
      next_st.remain = half - 4'h1;
      next_st.rd     = ca_r[CA_DIR];
      next_st.addr   = lpb_step(cmd_addr, half);
    end else if (bst_cmd) begin
      next_st.remain = 4'h0;
    end else if (st.remain != 4'h0) begin
      next_st.remain = st.remain - 4'h1;
      next_st.addr   = lpb_step(st.addr, half);
    end
    // read output: preamble one clock ahead of the first pair
    next_st.s1_v   = rd_p.out_valid;
    next_st.s1_a   = rd_p.out_addr;
    next_st.dq_oe  = st.s1_v;
    next_st.dqs_oe = rd_p.out_valid || st.s1_v;
    next_st.dqs_o  = st.s1_v;
    next_st.dq     = st.s1_v ? mem[st.s1_a] : '0;
    next_st.wr_v_d = wr_p.out_valid;
    // burst-end toggles for the system side
    next_st.rd_tg  = st.rd_tg ^ (st.dq_oe && !st.s1_v);
    next_st.wr_tg  = st.wr_tg ^ (st.wr_v_d && !wr_p.out_valid);
    next_st.busy   = (st.remain != 4'h0) || rd_p.busy || wr_p.busy || st.s1_v
                     || st.dq_oe;
  end

  always_ff @(posedge ck_link) begin
    if (link_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // write capture on each strobed pair inside the write window
  always_ff @(posedge ck_link) begin
    if (wr_p.out_valid && dqs_i) begin
      mem[wr_p.out_addr] <= dq_i;
    end
  end

  assign dq_o   = st.dq;
  assign dq_oe  = st.dq_oe;
  assign dqs_o  = st.dqs_o;
  assign dqs_oe = st.dqs_oe;

  ////////////////////////////////////////////////////////////////////////////
  // system side: edge detect of synchronised toggles
  always_comb begin
    next_sst        = sst;
    next_sst.rd_tg  = evt_s[0];
    next_sst.wr_tg  = evt_s[1];
    next_sst.evt_rd = evt_s[0] ^ sst.rd_tg;
    next_sst.evt_wr = evt_s[1] ^ sst.wr_tg;
    next_sst.busy   = evt_s[2];
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sst <= '0;
    end else begin
      sst <= next_sst;
    end
  end

  assign evt_rd_end = sst.evt_rd;
  assign evt_wr_end = sst.evt_wr;
  assign link_busy  = sst.busy;

  ////////////////////////////////////////////////////////////////////////////
  // latency check counters, loaded only from an idle engine
  logic [3:0] chk_rd;
  logic [3:0] chk_wr;
  logic       idle;

  assign idle = !st.busy && (st.remain == 4'h0) && !rd_p.busy && !wr_p.busy
                && !st.s1_v && !st.dq_oe && chk_rd == 4'h0 && chk_wr == 4'h0;

  always_ff @(posedge ck_link) begin
    if (link_rst) begin
      chk_rd <= 4'h0;
      chk_wr <= 4'h0;
    end else begin
      if (rw_cmd && idle && ca_r[CA_DIR]) begin
        chk_rd <= rl;
      end else if (chk_rd != 4'h0) begin
        chk_rd <= chk_rd - 4'h1;
      end
      if (rw_cmd && idle && !ca_r[CA_DIR]) begin
        chk_wr <= wl + WR_TAP_EXT;
      end else if (chk_wr != 4'h0) begin
        chk_wr <= chk_wr - 4'h1;
      end
    end
  end

  a_cmd_decode: assert property (
    @(posedge ck_link) disable iff (link_rst)
    rw_cmd |-> (ca_r[CA_DIR] ? rd_p.in_valid : wr_p.in_valid)
  ) else $error("read/write command did not start its burst");

  a_col_capture: assert property (
    @(posedge ck_link) disable iff (link_rst)
    rw_cmd |=> st.addr == lpb_step($past(cmd_addr), half)
  ) else $error("burst start column not taken from command bus");

  a_read_latency: assert property (
    @(posedge ck_link) disable iff (link_rst)
    chk_rd == 4'h1 |=> $rose(st.dq_oe)
  ) else $error("first read data not at read latency");

  a_read_preamble: assert property (
    @(posedge ck_link) disable iff (link_rst)
    $rose(st.dq_oe) |-> $past(st.dqs_oe && !st.dqs_o) && st.dqs_o
  ) else $error("read strobe preamble missing");

  a_gapless_slots: assert property (
    @(posedge ck_link) disable iff (link_rst)
    (rw_cmd && half == 4'h2) ##1 (!rw_cmd && !bst_cmd) |-> inject_v
      ##1 (rw_cmd || !inject_v)
  ) else $error("burst slot count wrong for burst length");

  a_write_window: assert property (
    @(posedge ck_link) disable iff (link_rst)
    chk_wr == 4'h1 |-> $rose(wr_p.out_valid)
  ) else $error("write sampling window not at write latency");

  a_interrupt_len: assert property (
    @(posedge ck_link) disable iff (link_rst)
    (rw_cmd && st.remain != 4'h0) |=> st.remain == half - 4'h1
  ) else $error("interrupting command did not restart burst");

  a_bst_stops: assert property (
    @(posedge ck_link) disable iff (link_rst)
    bst_cmd |-> !inject_v ##1 (st.remain == 4'h0)
  ) else $error("terminate did not stop the latest burst");

endmodule

// ### verif/lpb_host.sv
/*
  memory controller model: drives command/address pins and write data.
  assumes: ck_link runs free; one caller per task at a time.
*/
`timescale 1ns/1ps
module lpb_host
  import lpb_pkg::*;
(
  input  wire logic       ck_link,
  output logic            cs_n,
  output logic [CA_W-1:0] ca_r,
  output logic [CA_W-1:0] ca_f,
  output logic [15:0]     dq_i,
  output logic            dqs_i
);
  // idle pins at time zero
  initial begin
    cs_n  = 1'b1;
    ca_r  = 10'h155;
    ca_f  = 10'h2AA;
    dq_i  = 16'hA55A;
    dqs_i = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one command, kind 0 write, 1 read, 2 terminate; spacing never below two
  task automatic cmd(input logic [1:0] kind, input logic [13:0] a, input int gap);
    repeat (gap - 2) @(posedge ck_link);
    @(posedge ck_link);
    #1;
    cs_n = 1'b0;
    ca_r = {a[13:11], a[1:0], 2'h0, kind == 2'h1, kind == 2'h2, 1'b1};
    ca_f = {a[10:2], 1'b0};
    @(posedge ck_link);
    #1;
    cs_n = 1'b1;
    ca_r = ~ca_r;
    ca_f = ~ca_f;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // contiguous write pairs after write latency, then bus released
  task automatic wdata(input int wl, input int n, input logic [15:0] base);
    repeat (wl) @(posedge ck_link);
    for (int k = 0; k < n; k++) begin
      #1;
      dq_i  = base + 16'(k * 16'h0101);
      dqs_i = 1'b1;
      @(posedge ck_link);
    end
    #1;
    dq_i  = ~dq_i;
    dqs_i = 1'b0;
  endtask
endmodule

// ### verif/lpb_burst_tb.sv
/*
  self-checking bench of the burst engine: seamless bursts in every burst
  length, truncated and interrupted bursts in burst length 8.
  assumes: lpb_host model on the link pins; storage starts unknown.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module lpb_burst_tb;
  import lpb_pkg::*;
  localparam logic [1:0]  WR = 2'h0;
  localparam logic [1:0]  RD = 2'h1;
  localparam logic [1:0]  TERM = 2'h2;
  localparam logic [13:0] A_ADDR = 14'h2840;
  localparam logic [13:0] B_ADDR = 14'h1C80;
  logic clk_sys, sys_rst, ck_link, cs_n, dqs_i, dq_oe, dqs_o, dqs_oe;
  logic evt_rd_end, evt_wr_end, link_busy;
  logic [3:0]      cfg_rl, cfg_wl;
  logic [1:0]      cfg_bl;
  logic [CA_W-1:0] ca_r, ca_f;
  logic [15:0]     dq_i, dq_o;
  logic [15:0]     exp_q [$];
  int              n_fail, compares, n_rde, n_wre;

  // clocks, unrelated in phase
  always #2 clk_sys = ~clk_sys;
  always #62.5 ck_link = ~ck_link;
  // stream end pulses
  always @(posedge clk_sys) begin
    if (evt_rd_end === 1'b1) n_rde++;
    if (evt_wr_end === 1'b1) n_wre++;
  end

  lpb_burst #(.DW(8), .AW(8)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cfg_rl(cfg_rl), .cfg_wl(cfg_wl), .cfg_bl(cfg_bl), .evt_rd_end(evt_rd_end),
    .evt_wr_end(evt_wr_end), .link_busy(link_busy), .ck_link(ck_link), .cs_n(cs_n),
    .ca_r(ca_r), .ca_f(ca_f), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_i(dqs_i),
    .dqs_o(dqs_o), .dqs_oe(dqs_oe));
  lpb_host u_host (.ck_link(ck_link), .cs_n(cs_n), .ca_r(ca_r), .ca_f(ca_f),
    .dq_i(dq_i), .dqs_i(dqs_i));

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic summarize();
    $display("counts: compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic setcfg(input logic [3:0] rl, input logic [3:0] wl, input logic [1:0] bl);
    @(posedge clk_sys);
    #1;
    cfg_rl = rl;
    cfg_wl = wl;
    cfg_bl = bl;
    repeat (6) @(posedge ck_link);
  endtask

  // wait for idle; turnaround gaps end far above the minimum
  // latency pipes stay busy until every stage has drained
  task automatic settle();
    repeat (3) @(posedge ck_link);
    for (int i = 0; i < 40 && link_busy !== 1'b0; i++) @(posedge ck_link);
    `CHK(link_busy, 1'b0)
  endtask

  // preamble, then every queued pair, then release
  task automatic rchk(input logic [3:0] rl);
    repeat (rl - 1) @(posedge ck_link);
    #1;
    `CHK({dqs_oe, dqs_o, dq_oe}, 3'h4)
    foreach (exp_q[i]) begin
      @(posedge ck_link);
      #1;
      `CHK({dq_oe, dqs_o, dq_o}, {2'h3, exp_q[i]})
    end
    @(posedge ck_link);
    #1;
    `CHK({dq_oe, dqs_oe, dq_o}, 18'h0)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_seamless();
    logic [3:0]  rl, wl, h;
    logic [15:0] base;
    int          rd0, wr0;
    for (int c = 0; c < 3; c++) begin
      rl = (c == 2) ? 4'h8 : 4'(3 + 2 * c);
      wl = (c == 2) ? 4'h4 : 4'(1 + c);
      h = 4'(2 << c);
      base = 16'(16'h1000 * (c + 1));
      setcfg(rl, wl, 2'(c));
      rd0 = n_rde;
      wr0 = n_wre;
      u_host.cmd(WR, A_ADDR, 2);
      fork
        u_host.cmd(WR, B_ADDR, h);
        u_host.wdata(wl, 2 * h, base);
      join
      settle();
      exp_q.delete();
      for (int k = 0; k < 2 * h; k++) exp_q.push_back(base + 16'(k * 16'h0101));
      u_host.cmd(RD, A_ADDR, 2);
      fork
        u_host.cmd(RD, B_ADDR, h);
        rchk(rl);
      join
      settle();
      `CHK(n_rde - rd0, 1)
      `CHK(n_wre - wr0, 1)
    end
    $display("done: seamless bursts");
  endtask

  task automatic t_terminate();
    setcfg(4'h3, 4'h1, BL_CODE_8);
    u_host.cmd(WR, A_ADDR, 2);
    u_host.wdata(1, 4, 16'h3000);
    settle();
    u_host.cmd(WR, A_ADDR, 2);
    fork
      u_host.cmd(TERM, A_ADDR, 2);
      u_host.wdata(1, 4, 16'h4000);
    join
    settle();
    exp_q = '{16'h4000, 16'h4101};
    u_host.cmd(RD, A_ADDR, 2);
    fork
      u_host.cmd(TERM, A_ADDR, 2);
      rchk(4'h3);
    join
    settle();
    exp_q = '{16'h4000, 16'h4101, 16'h3202, 16'h3303};
    u_host.cmd(RD, A_ADDR, 2);
    rchk(4'h3);
    settle();
    $display("done: terminated bursts");
  endtask

  // same-direction interrupts only, on even spacing
  task automatic t_interrupt();
    u_host.cmd(WR, A_ADDR, 2);
    u_host.wdata(1, 4, 16'h5000);
    settle();
    u_host.cmd(WR, A_ADDR, 2);
    fork
      u_host.cmd(WR, B_ADDR, 2);
      u_host.wdata(1, 6, 16'h6000);
    join
    settle();
    exp_q = '{16'h6000, 16'h6101, 16'h6202, 16'h6303, 16'h6404, 16'h6505};
    u_host.cmd(RD, A_ADDR, 2);
    fork
      u_host.cmd(RD, B_ADDR, 2);
      rchk(4'h3);
    join
    settle();
    exp_q = '{16'h6000, 16'h6101, 16'h5202, 16'h5303};
    u_host.cmd(RD, A_ADDR, 2);
    rchk(4'h3);
    settle();
    $display("done: interrupted bursts");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    clk_sys = 1'b0;
    ck_link = 1'b0;
    sys_rst = 1'b1;
    cfg_rl = 4'h3;
    cfg_wl = 4'h1;
    cfg_bl = 2'h0;
    repeat (4) @(posedge ck_link);
    @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    repeat (3) @(posedge ck_link);
    #1;
    `CHK({dq_oe, dqs_oe, dqs_o, link_busy, dq_o}, 20'h0)
    t_seamless();
    t_terminate();
    t_interrupt();
    summarize();
  end

  // watchdog against a hung handshake
  initial begin
    #300000;
    n_fail++;
    summarize();
  end
endmodule
